// File: servo_drive_model.sv
`timescale 1ns/100ps
// ==================================================================
// behavioural drive at the far end of the byte link
module servo_drive_model #(
   parameter logic [6:0] own_id = 7'h05
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // bytes from the controller
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   output logic             tx_ready,
   // bytes back to the controller
   output logic             rx_valid,
   output logic [7:0]       rx_data,
   // bench knobs and views
   input  wire logic        slow,
   input  wire logic        bad_sum,
   input  wire logic [27:0] reply_val,
   output logic [7:0]       pkt [8],
   output logic [7:0]       n_pkt,
   output logic [6:0]       cfg
);
   int          idx;
   int          len;
   logic [6:0]  s;
   logic [27:0] v;
   logic [27:0] pos;
   logic        ph;
   logic [7:0]  rq [$];
   // slow mode stalls every other cycle so the sender must hold
   assign tx_ready = !slow || ph;
   // answer in the widest form, four data groups
   task automatic reply(input logic [4:0] f);
      logic [7:0] b [7];
      logic [6:0] c;
      b[0] = {1'b0, own_id};
      b[1] = {3'b111, f};
      for (int i = 0; i < 4; i++)
         b[2 + i] = {1'b1, reply_val[27 - 7 * i -: 7]};
      c = 7'h00;
      for (int i = 0; i < 6; i++)
         c += b[i][6:0];
      b[6] = {1'b1, c ^ {6'h00, bad_sum}};
      foreach (b[i])
         rq.push_back(b[i]);
   endtask
   // collect packets, check them, act on those meant for this drive
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph <= 1'b0;
         idx = 0;
         len = 7;
         n_pkt <= 8'h00;
         pos <= 28'h0;
         cfg <= 7'h00;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
         rq.delete();
      end else begin
         ph <= !ph;
         rx_valid <= 1'b0;
         rx_data <= ~rx_data; // an idle line never holds its last byte
         if (rq.size() > 0 && !rx_valid) begin
            rx_valid <= 1'b1;
            rx_data <= rq.pop_front();
         end
         if (tx_valid && tx_ready) begin
            if (!tx_data[7])
               idx = 0;
            pkt[idx] = tx_data;
            if (idx == 1)
               len = 4 + tx_data[6:5];
            if (idx == 2)
               v = {{21{tx_data[6]}}, tx_data[6:0]};
            else if (idx > 2 && idx < len - 1)
               v = {v[20:0], tx_data[6:0]};
            idx++;
            if (idx == len) begin
               n_pkt <= n_pkt + 8'h01;
               s = 7'h00;
               for (int i = 0; i < len - 1; i++)
                  s += pkt[i][6:0];
               // id byte (own_id or broadcast 7f) and checksum decide; other packets are ignored
               if (tx_data == {1'b1, s} && (pkt[0][6:0] == own_id ||
                   pkt[0][6:0] == 7'h7f)) begin
                  case (pkt[1][4:0])
                     5'h00: pos <= 28'h0;
                     5'h01: pos <= v;
                     5'h03: pos <= pos + v;
                     5'h07: cfg <= pkt[2][6:0];
                     default: if (pkt[1][4:3] == 2'b11 || pkt[1][4:0] == 5'h09)
                        reply(pkt[1][4:0]);
                  endcase
               end
            end
         end
      end
   end
endmodule : servo_drive_model

// File: servo_host_checker.sv
`timescale 1ns/100ps
// ==================================================================
// watches the controller ports for bus and framing slips
module servo_host_checker (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // byte links
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_ready,
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_data
);
   logic [2:0] idx;
   logic [2:0] len;
   logic [6:0] sum;
   wire        hs = tx_valid && tx_ready;
   wire        last = hs && idx != 3'h0 && idx == len - 3'h1;
   // byte place in the packet; a clear top bit always restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx <= 3'h0;
         len <= 3'h7;
         sum <= 7'h00;
      end else if (hs) begin
         idx <= !tx_data[7] ? 3'h1 : (last || idx == 3'h0) ? 3'h0 : idx + 3'h1;
         sum <= (tx_data[7] ? sum : 7'h00) + tx_data[6:0];
         if (idx == 3'h1)
            len <= 3'h4 + {1'b0, tx_data[6:5]};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_wait; psel && penable && !pready |=> pready; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_err; pslverr |-> pready && psel && penable; endproperty
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   property p_id; hs && idx == 3'h0 |-> !tx_data[7]; endproperty
   property p_top; hs && idx != 3'h0 |-> tx_data[7]; endproperty
   property p_sum; last |-> tx_data == {1'b1, sum}; endproperty
   property p_gap; last |=> !tx_valid [*4]; endproperty
   a_wait: assert property (p_wait) else $error("pready late");
   a_pulse: assert property (p_pulse) else $error("pready too long");
   a_err: assert property (p_err) else $error("pslverr without pready");
   a_hold: assert property (p_hold) else $error("byte dropped early");
   a_id: assert property (p_id) else $error("id byte top bit set");
   a_top: assert property (p_top) else $error("top bit clear");
   a_sum: assert property (p_sum) else $error("bad checksum byte");
   a_gap: assert property (p_gap) else $error("gap after packet short");
   c_stall: cover property (tx_valid && !tx_ready);
   c_last: cover property (last);
   c_err: cover property (pslverr);
endmodule : servo_host_checker

bind servo_host_ctrl servo_host_checker checker_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .tx_valid(tx_valid),
   .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
   .rx_data(rx_data));

// File: servo_host_ctrl.sv
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
module servo_host_ctrl (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // serial byte stream to the drive chain
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   input  wire logic        tx_ready,
   // serial byte stream from the drive chain
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data
);
   // ==================================================================
   // state
   typedef enum logic [2:0] {
      st_idle, st_id, st_func, st_data, st_sum, st_gap
   } tx_state_t;

   typedef struct packed {
      tx_state_t                  tx_st;
      logic [6:0]                 id;
      logic [4:0]                 func;
      logic [27:0]                value;
      logic [3:0][6:0]            grp;
      logic [2:0]                 cnt;
      logic [2:0]                 idx;
      logic [6:0]                 sum;
      logic [7:0]                 gap;
      servo_link_pkg::byte_beat_t tx;
      logic [7:0][7:0]            rbuf;
      logic [2:0]                 rnum;
      logic [2:0]                 rlen;
      logic [27:0]                reply_val;
      logic [4:0]                 reply_func;
      logic                       reply_new;
      logic                       sum_err;
      logic                       sent;
      logic                       bad_arg;
      servo_link_pkg::apb_answer_t apb;
   } state_t;

   state_t           cur;
   state_t           next_cur;
   logic [3:0][6:0]  enc_groups;
   logic [2:0]       enc_count;
   logic             acc;
   logic             wr;
   logic [6:0]       rsum;
   logic [27:0]      rval;
   logic [2:0]       rtot;
   logic [6:0]       feed_lo;

   // ==================================================================
   // encoder for the outgoing value
   servo_packet_encoder u_enc (
      .value  (cur.value),
      .groups (enc_groups),
      .count  (enc_count)
   );

   assign acc = psel & penable & ~cur.apb.pready;
   assign wr  = acc & pwrite;

   // ==================================================================
   // next state
   always_comb begin
      next_cur = cur;
      rsum     = 7'h00;
      rval     = 28'h0;
      rtot     = 3'd0;
      feed_lo  = pwdata[6:0];
      next_cur.apb.pready  = acc;
      next_cur.apb.pslverr = 1'b0;
      next_cur.tx.valid    = cur.tx.valid & ~tx_ready;

      // apb register access, answered in the second access cycle
      if (acc) begin
         next_cur.apb.prdata = 32'h0;
         case (paddr)
            servo_link_pkg::off_ctrl: begin
               next_cur.apb.prdata = {cur.tx_st != st_idle, 18'h0,
                                      cur.func, 1'b0, cur.id};
               if (pwrite && pwdata[servo_link_pkg::ctrl_go_bit] &&
                   cur.tx_st == st_idle) begin
                  next_cur.id   = pwdata[6:0] & 7'h7f;
                  next_cur.func = pwdata[12:8];
                  next_cur.sent = 1'b0;
                  // feed of a line move must be 1..127: flag, still send
                  next_cur.bad_arg = 1'b0;
                  next_cur.tx_st   = st_id;
               end else if (pwrite && cur.tx_st != st_idle) begin
                  next_cur.apb.pslverr = 1'b1;  // busy: start refused
               end
            end
            servo_link_pkg::off_value: begin
               next_cur.apb.prdata = {4'h0, cur.value};
               if (pwrite && cur.tx_st == st_idle) begin
                  next_cur.value = pwdata[27:0];
                  if (pwdata[31]) begin
                     // plane-feed word for the last arc packet
                     // negative feed must sign-extend over the whole value
                     next_cur.value = {12'h000, pwdata[23:16], 8'h00} |
                                      28'(signed'(feed_lo));
                  end
               end
            end
            servo_link_pkg::off_status: begin
               // last reply code sits here so the value keeps all 28 bits
               next_cur.apb.prdata = {19'h0, cur.reply_func, 2'h0,
                                      cur.bad_arg, cur.sent,
                                      cur.sum_err, cur.reply_new,
                                      2'b00};
               if (wr) begin
                  // write-one-to-clear; a new event wins over the clear
                  if (pwdata[2]) next_cur.reply_new = 1'b0;
                  if (pwdata[3]) next_cur.sum_err   = 1'b0;
                  if (pwdata[4]) next_cur.sent      = 1'b0;
               end
            end
            servo_link_pkg::off_reply: begin
               // full signed value, sign-extended to the bus word
               next_cur.apb.prdata = {{4{cur.reply_val[27]}},
                                      cur.reply_val};
            end
            servo_link_pkg::off_txbyte: begin
               next_cur.apb.prdata = {24'h0, cur.tx.data};
            end
            default: next_cur.apb.pslverr = 1'b1;
         endcase
      end

      // outgoing packet sequencer
      case (cur.tx_st)
         st_idle: ;
         st_id: begin
            if (!cur.tx.valid) begin
               next_cur.grp = enc_groups;
               next_cur.cnt = enc_count;
               if (cur.func == servo_link_pkg::fn_set_config ||
                   cur.func == servo_link_pkg::fn_set_origin) begin
                  next_cur.cnt = 3'd1;
                  next_cur.grp[0] = cur.value[6:0];
               end
               if (cur.func == servo_link_pkg::fn_line &&
                   (cur.value == 28'h0 || cur.value[27] ||
                    cur.value > 28'd127)) begin
                  next_cur.bad_arg = 1'b1;
               end
               next_cur.tx.valid = 1'b1;
               next_cur.tx.data  = {1'b0, cur.id};
               next_cur.sum      = cur.id;
               next_cur.tx_st    = st_func;
            end
         end
         st_func: begin
            if (!cur.tx.valid || tx_ready) begin
               next_cur.tx.valid = 1'b1;
               // length field in bits 6:5
               next_cur.tx.data  = servo_link_pkg::top_bit +
                  8'((cur.cnt - 3'd1) * servo_link_pkg::len_mult) +
                  {3'h0, cur.func};
               next_cur.sum   = cur.sum + next_cur.tx.data[6:0];
               next_cur.idx   = 3'd0;
               next_cur.tx_st = st_data;
            end
         end
         st_data: begin
            if (tx_ready) begin
               next_cur.tx.valid = 1'b1;
               next_cur.tx.data  = servo_link_pkg::top_bit |
                                   {1'b0, cur.grp[cur.idx[1:0]]};
               next_cur.sum = cur.sum + cur.grp[cur.idx[1:0]];
               next_cur.idx = cur.idx + 3'd1;
               if (cur.idx + 3'd1 == cur.cnt) next_cur.tx_st = st_sum;
            end
         end
         st_sum: begin
            if (tx_ready) begin
               next_cur.tx.valid = 1'b1;
               // modulo 128 falls out of the 7-bit sum
               next_cur.tx.data  = servo_link_pkg::top_bit |
                                   {1'b0, cur.sum};
               next_cur.gap   = 8'(servo_link_pkg::byte_gap_cyc);
               next_cur.tx_st = st_gap;
            end
         end
         st_gap: begin
            // hold off the next packet so the chain can relay it
            if (!cur.tx.valid || tx_ready) begin
               next_cur.gap = cur.gap - 8'd1;
               if (cur.gap <= 8'd1) begin
                  // sent paces the packets of a line or arc move in order
                  next_cur.sent  = 1'b1;
                  next_cur.tx_st = st_idle;
               end
            end
         end
         default: next_cur.tx_st = st_idle;
      endcase

      // reply collector: a clear top bit restarts the packet
      if (rx_valid) begin
         if (!rx_data[7]) begin
            next_cur.rbuf[0] = rx_data;
            next_cur.rnum    = 3'd1;
            next_cur.rlen    = 3'd0;
         end else if (cur.rnum != 3'd0) begin
            next_cur.rbuf[cur.rnum] = rx_data;
            next_cur.rnum = cur.rnum + 3'd1;
            if (cur.rnum == 3'd1) begin
               next_cur.rlen = 3'(servo_link_pkg::min_len) +
                               {1'b0, rx_data[6:5]};
            end
            rtot = (cur.rnum == 3'd1) ?
                   3'(servo_link_pkg::min_len) + {1'b0, rx_data[6:5]} :
                   cur.rlen;
            if (cur.rnum + 3'd1 == rtot) begin
               for (int i = 0; i < 7; i++) begin
                  if (3'(i) < cur.rnum) rsum = rsum + cur.rbuf[i][6:0];
               end
               rval = {{21{cur.rbuf[2][6]}}, cur.rbuf[2][6:0]};
               for (int i = 3; i < 7; i++) begin
                  if (3'(i) < cur.rnum) rval = {rval[20:0],
                                                cur.rbuf[i][6:0]};
               end
               if (cur.rnum == 3'd2) rval = {{21{cur.rbuf[2][6]}},
                                             cur.rbuf[2][6:0]};
               next_cur.rnum = 3'd0;
               if (rsum != rx_data[6:0]) begin
                  next_cur.sum_err = 1'b1;
               end else begin
                  next_cur.reply_val  = rval;
                  next_cur.reply_func = cur.rbuf[1][4:0];
                  next_cur.reply_new  = 1'b1;
               end
            end
         end
      end
   end

   // ==================================================================
   // one register for all state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign pready   = cur.apb.pready;
   assign pslverr  = cur.apb.pslverr;
   assign prdata   = cur.apb.prdata;
   assign tx_valid = cur.tx.valid;
   assign tx_data  = cur.tx.data;
endmodule : servo_host_ctrl

// File: servo_host_ctrl_bench.sv
`timescale 1ns/100ps
// ==================================================================
// self-checking bench for the serial command controller
module servo_host_ctrl_bench;
   logic        pclk = 1'b0, presetn = 1'b0, slow = 1'b0, bad_sum = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, re;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic        pready, pslverr, tx_valid, tx_ready, rx_valid;
   logic [7:0]  tx_data, rx_data, n_pkt;
   logic [7:0]  pkt [8];
   logic [6:0]  cfg;
   logic [27:0] reply_val = 28'h0;
   int          n_fail = 0, checks = 0;
   // 40 MHz
   always #12.5 pclk = ~pclk;
   servo_host_ctrl servo_host_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data));
   servo_drive_model servo_drive_model_inst (
      .pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .slow(slow), .bad_sum(bad_sum),
      .reply_val(reply_val), .pkt(pkt), .n_pkt(n_pkt), .cfg(cfg));
   // ==================================================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one transfer: setup, access until pready, release after it
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // pready is looked at on rising edges only; request held till then
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1)
         n_fail++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // poll status until a flag rises, bounded
   task automatic wait_flag(input int b);
      rv = 32'h0;
      for (int i = 0; i < 300 && rv[b] !== 1'b1; i++)
         apb(1'b0, servo_link_pkg::off_status, 32'h0, rv, re);
      if (rv[b] !== 1'b1)
         n_fail++;
   endtask : wait_flag
   // clear old flags, load value, start, wait until it has left
   task automatic send(input logic [6:0] id, input logic [4:0] f,
                       input logic [31:0] v);
      apb(1'b1, servo_link_pkg::off_status, 32'h3c, rv, re);
      apb(1'b1, servo_link_pkg::off_value, v, rv, re);
      apb(1'b1, servo_link_pkg::off_ctrl, {1'b1, 18'h0, f, 1'b0, id}, rv, re);
      wait_flag(4);
   endtask : send
   // ==================================================================
   // scenarios
   task automatic t_refuse;
      apb(1'b0, servo_link_pkg::off_status, 32'h0, rv, re);
      check("status reset", rv, 32'h0);
      apb(1'b0, 8'h14, 32'h0, rv, re);
      check("unmapped", re, 1'b1);
      apb(1'b1, servo_link_pkg::off_ctrl, 32'h8000_0305, rv, re);
      apb(1'b1, servo_link_pkg::off_ctrl, 32'h8000_0305, rv, re);
      check("busy start", re, 1'b1);
      wait_flag(4);
      apb(1'b0, servo_link_pkg::off_ctrl, 32'h0, rv, re);
      check("ctrl readback", rv, 32'h0000_0305);
   endtask : t_refuse
   // moves, spin, origin and both arc words, with a stalling drive
   task automatic t_known;
      logic [6:0]  id [8] = '{3, 3, 2, 2, 3, 3, 7'h7f, 7'h7f};
      logic [4:0]  fn [8] = '{3, 3, 5'h0a, 5'h0a, 0, 1, 4, 4};
      logic [31:0] vl [8] = '{120, 32'h0fffff88, 60, 32'h0fffffc4, 0, 0,
                              32'h8001_0001, 32'h8000_007f};
      logic [39:0] ex [8] = '{40'h03a380f89e, 40'h03a3ff88ad,
         40'h028abcc800, 40'h028ac4d000, 40'h0380808300,
         40'h0381808400, 40'h7fa48281a6, 40'h7f84ff8200};
      slow <= 1'b1;
      foreach (fn[k]) begin
         send(id[k], fn[k], vl[k]);
         for (int j = 0; j < 4 + ex[k][30:29]; j++)
            check("byte", pkt[j], ex[k][39 - 8 * j -: 8]);
         check("code", pkt[1][4:0], fn[k]);
         check("first data", pkt[2], ex[k][23:16]);
      end
      slow <= 1'b0;
   endtask : t_known
   // two line moves; the second ends with a zero feed rate
   task automatic t_line;
      logic [31:0] vl [8] = '{100, 200, 0, 3, 100, 200, 0, 0};
      logic [7:0]  n0;
      n0 = n_pkt;
      foreach (vl[k]) begin
         send(7'h7f, 5'h02, vl[k]);
         check("line head", {pkt[0], pkt[1][4:0]}, {8'h7f, 5'h02});
         if (k % 4 == 3)
            check("bad feed", rv[5], k > 3);
      end
      check("line count", n_pkt, n0 + 8'h08);
   endtask : t_line
   // status and parameter reads, replies at both range ends
   task automatic t_reply;
      logic [4:0] fn [9] = '{9, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c,
                             5'h1d, 5'h1e, 5'h1f};
      foreach (fn[k]) begin
         reply_val <= k[0] ? 28'h8000000 : 28'h7ffffff - k;
         send(7'h05, fn[k], 32'h0);
         wait_flag(2);
         check("reply code", rv[12:8], fn[k]);
         apb(1'b0, servo_link_pkg::off_reply, 32'h0, rv, re);
         check("reply", rv, {{4{reply_val[27]}}, reply_val});
      end
   endtask : t_reply
   // a reply with a broken checksum is dropped
   task automatic t_bad;
      bad_sum <= 1'b1;
      send(7'h05, 5'h09, 32'h0);
      wait_flag(3);
      check("sum error", rv[3:2], 2'b10);
      bad_sum <= 1'b0;
   endtask : t_bad
   // configuration write carries one byte and gets no answer
   task automatic t_config;
      send(7'h05, 5'h07, 32'h21);
      repeat (60) @(posedge pclk);
      apb(1'b0, servo_link_pkg::off_status, 32'h0, rv, re);
      check("config bytes", {pkt[1], pkt[2]}, 16'h87a1);
      check("drive config", cfg, 7'h21);
      check("no reply", rv[2], 1'b0);
      apb(1'b0, servo_link_pkg::off_txbyte, 32'h0, rv, re);
      check("last byte", rv, 32'h0000_00ad);
      apb(1'b0, servo_link_pkg::off_value, 32'h0, rv, re);
      check("value readback", rv, 32'h0000_0021);
   endtask : t_config
   task automatic finish_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_refuse;
      t_known;
      t_line;
      t_reply;
      t_bad;
      t_config;
      finish_test;
   end
   // watchdog: the tests need well under this span
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      finish_test;
   end
endmodule : servo_host_ctrl_bench

// File: servo_link_pkg.sv
package servo_link_pkg;
   // ==================================================================
   // register map of the controller (byte addresses)
   localparam logic [7:0] off_ctrl    = 8'h00;
   localparam logic [7:0] off_value   = 8'h04;
   localparam logic [7:0] off_status  = 8'h08;
   localparam logic [7:0] off_reply   = 8'h0c;
   localparam logic [7:0] off_txbyte  = 8'h10;
   // ctrl field positions
   localparam int ctrl_id_lsb   = 0;
   localparam int ctrl_func_lsb = 8;
   localparam int ctrl_go_bit   = 31;
   // ==================================================================
   // packet coding
   localparam logic [7:0] top_bit      = 8'h80;
   localparam logic [6:0] group_mask   = 7'h7f;
   localparam logic [6:0] broadcast_id = 7'h7f;
   localparam int         len_mult     = 32;
   localparam int         max_groups   = 4;
   localparam int         min_len      = 4;
   localparam int         arc_shift    = 8;
   // function codes
   localparam logic [4:0] fn_set_origin  = 5'h00;
   localparam logic [4:0] fn_go_abs      = 5'h01;
   localparam logic [4:0] fn_line        = 5'h02;
   localparam logic [4:0] fn_go_rel      = 5'h03;
   localparam logic [4:0] fn_arc         = 5'h04;
   localparam logic [4:0] fn_set_config  = 5'h07;
   localparam logic [4:0] fn_read_status = 5'h09;
   localparam logic [4:0] fn_spin        = 5'h0a;
   localparam logic [4:0] fn_param_lo    = 5'h18;
   localparam logic [4:0] fn_param_hi    = 5'h1f;
   // config fields sent by fn_set_config, then a status bit position
   localparam int cfg_src_lsb  = 0;
   localparam int cfg_free_bit = 5;
   localparam int status_busy_bit = 5;
   // ==================================================================
   // timing: byte slot on the serial side, in ns, cycles derived
   localparam int clk_period_ns = 25;
   localparam int byte_gap_ns   = 100;
   localparam int byte_gap_cyc  =
      (byte_gap_ns + clk_period_ns - 1) / clk_period_ns;

   // byte stream carrier
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } byte_beat_t;

   // apb slave answer
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_answer_t;
endpackage : servo_link_pkg

// File: servo_packet_encoder.sv
`timescale 1ns/100ps
// splits a signed 28-bit value into the fewest 7-bit groups
module servo_packet_encoder (
   // value to encode
   input  wire logic [27:0] value,
   // encoded groups, most significant first, plus count
   output logic [3:0][6:0]  groups,
   output logic [2:0]       count
);
   logic signed [27:0] sv;

   // narrowest form that still sign-extends back to the value
   always_comb begin
      sv = signed'(value);
      for (int i = 0; i < servo_link_pkg::max_groups; i++) begin
         groups[i] = 7'h00;
      end
      if (sv >= -28'sd64 && sv <= 28'sd63) begin
         count = 3'd1;
         groups[0] = value[6:0];
      end else if (sv >= -28'sd8192 && sv <= 28'sd8191) begin
         count = 3'd2;
         groups[0] = value[13:7];
         groups[1] = value[6:0];
      end else if (sv >= -28'sd1048576 && sv <= 28'sd1048575) begin
         count = 3'd3;
         groups[0] = value[20:14];
         groups[1] = value[13:7];
         groups[2] = value[6:0];
      end else begin
         count = 3'd4;
         groups[0] = value[27:21];
         groups[1] = value[20:14];
         groups[2] = value[13:7];
         groups[3] = value[6:0];
      end
   end
endmodule : servo_packet_encoder
